/* File: core/i2cma_top.sv */
// Bus arbitration master engine with Wishbone register access.
// Assumes open-drain pads outside; output enable low pulls the line low.
`timescale 1ns/1ps
`default_nettype none
module i2cma_top
   import i2cma_pkg::*;
(
   input  wire logic        clock,
   input  wire logic        rst,
   input  wire logic        wb_cyc_i,
   input  wire logic        wb_stb_i,
   input  wire logic        wb_we_i,
   input  wire logic [7:0]  wb_adr_i,
   input  wire logic [3:0]  wb_sel_i,
   input  wire logic [31:0] wb_dat_i,
   output logic [31:0]      wb_dat_o,
   output logic             wb_ack_o,
   input  wire logic        scl_i,
   output logic             scl_o,
   output logic             scl_oe,
   input  wire logic        sda_i,
   output logic             sda_o,
   output logic             sda_oe,
   output logic             irq,
   output logic             wake
);
   import i2cma_pkg::*;

   i2cma_state_type  state_q;
   i2cma_lines_type  pins;
   i2cma_lines_type  ln;
   i2cma_req_type    req;
   logic [2:0]       ctrl_q;
   logic [4:0]       seq_q;
   logic [6:0]       baud_q;
   logic [7:0]       buf_q;
   logic [7:0]       shift_q;
   logic [3:0]       bit_q;
   logic             full_q;
   logic             sflag_q;
   logic             pflag_q;
   logic             write_collision_flag_q;
   logic             bcol_q;
   logic             pirq_q;
   logic             nack_q;
   logic             sda_drv_q;
   logic             scl_drv_q;
   logic             ack_q;
   logic             brg_load;
   logic             brg_run;
   logic             brg_exp;
   logic             start_seen;
   logic             stop_seen;
   logic             wr;
   logic             bus_col;
   logic             seq_done;
   logic             byte_done;
   logic             en;
   logic             scl_up_q;

   assign pins.scl = scl_i;
   assign pins.sda = sda_i;
   assign req.adr  = wb_adr_i;
   assign req.we   = wb_we_i;
   assign req.sel  = wb_sel_i;
   assign req.dat  = wb_dat_i;
   assign en       = ctrl_q[CTRL_EN];

   function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
      hit = (a == off);
   endfunction

   i2cma_sync u_sync (
      .clock      (clock),
      .rst        (rst),
      .pins       (pins),
      .lines      (ln),
      .start_seen (start_seen),
      .stop_seen  (stop_seen)
   );

   i2cma_baud #(.WIDTH(I2CMA_BAUD_W)) u_baud (
      .clock   (clock),
      .rst     (rst),
      .load    (brg_load),
      .run     (brg_run),
      .reload  (baud_q),
      .expired (brg_exp)
   );

   // Wishbone: one wait state, ack drops after one cycle
   assign wr = wb_cyc_i && wb_stb_i && wb_we_i && !ack_q && req.sel[0];
   always_ff @(posedge clock) begin
      if (rst) begin
         ack_q <= 1'b0;
      end else begin
         ack_q <= wb_cyc_i && wb_stb_i && !ack_q;
      end
   end
   assign wb_ack_o = ack_q;

   always_ff @(posedge clock) begin
      if (rst) begin
         wb_dat_o <= '0;
      end else if (wb_cyc_i && wb_stb_i && !ack_q) begin
         wb_dat_o <= '0;
         if (hit(req.adr, I2CMA_ADR_CTRL)) wb_dat_o[2:0] <= ctrl_q;
         if (hit(req.adr, I2CMA_ADR_SEQ)) wb_dat_o[4:0] <= seq_q;
         if (hit(req.adr, I2CMA_ADR_BAUD)) wb_dat_o[6:0] <= baud_q;
         if (hit(req.adr, I2CMA_ADR_BUF)) wb_dat_o[7:0] <= buf_q;
         if (hit(req.adr, I2CMA_ADR_STATUS)) begin
            wb_dat_o[6:0] <= {nack_q, pirq_q, bcol_q, write_collision_flag_q,
                              pflag_q, sflag_q, full_q};
         end
      end
   end

   always_ff @(posedge clock) begin
      if (rst) begin
         ctrl_q <= '0;
         baud_q <= I2CMA_BAUD_RESET;
      end else begin
         if (wr && hit(req.adr, I2CMA_ADR_CTRL)) ctrl_q <= req.dat[2:0];
         if (wr && hit(req.adr, I2CMA_ADR_BAUD)) baud_q <= req.dat[6:0];
      end
   end

   // Collision: driven high released line read low while SCL high
   // arbitration loss
   always_comb begin
      bus_col = 1'b0;
      case (state_q)
         I2CMA_ST1: bus_col = !ln.sda || !ln.scl;
         I2CMA_ST2: bus_col = !sda_drv_q && ln.sda && !ln.scl;
         // Slave acknowledge low is not lost arbitration
         I2CMA_BHI: bus_col = !sda_drv_q && !ln.sda && ln.scl
                              && (bit_q < 4'h8 || seq_q[SEQ_ACK]);
         I2CMA_RS3: bus_col = !ln.scl && ln.sda;
         I2CMA_SP2: bus_col = scl_up_q && !ln.scl;
         I2CMA_SP3: bus_col = brg_exp && !ln.sda;
         I2CMA_RS2: bus_col = ln.scl && !ln.sda;
         default:   bus_col = 1'b0;
      endcase
   end

   // SCL read high since STOP released it; stretching is not a collision
   always_ff @(posedge clock) begin
      scl_up_q <= !rst && state_q == I2CMA_SP2 && (scl_up_q || ln.scl);
   end

   // Sequence control bits; a write while busy is ignored, except that ACKDT (seq_q[4]) still takes it
   // clear enables on collision
   always_ff @(posedge clock) begin
      if (rst || !en || bus_col || seq_done) begin
         seq_q[3:0] <= '0;
      end else if (wr && hit(req.adr, I2CMA_ADR_SEQ)
                   && state_q == I2CMA_IDLE) begin
         seq_q[3:0] <= req.dat[3:0];
      end
      if (rst) begin
         seq_q[4] <= 1'b0;
      end else if (wr && hit(req.adr, I2CMA_ADR_SEQ)) begin
         seq_q[4] <= req.dat[SEQ_ACKDT];
      end
   end

   // Main sequencer
   always_ff @(posedge clock) begin
      if (rst || !en) begin
         state_q   <= I2CMA_IDLE;
         sda_drv_q <= 1'b0;
         scl_drv_q <= 1'b0;
         bit_q     <= '0;
         shift_q   <= '0;
         nack_q    <= 1'b0;
      end else if (bus_col) begin
         state_q   <= I2CMA_IDLE;
         sda_drv_q <= 1'b0;
         scl_drv_q <= 1'b0;
         bit_q     <= '0;
      end else begin
         case (state_q)
            I2CMA_IDLE: begin
               if (seq_q[SEQ_START]) begin
                  state_q <= I2CMA_ST1;
               end else if (seq_q[SEQ_RSTART]) begin
                  sda_drv_q <= 1'b0;
                  state_q   <= I2CMA_RS1;
               end else if (seq_q[SEQ_STOP]) begin
                  sda_drv_q <= 1'b1;
                  state_q   <= I2CMA_SP1;
               end else if (seq_q[SEQ_ACK]) begin
                  sda_drv_q <= !seq_q[SEQ_ACKDT];
                  state_q   <= I2CMA_BLO;
                  bit_q     <= 4'h8;
               end else if (full_q) begin
                  shift_q <= buf_q;
                  bit_q   <= '0;
                  state_q <= I2CMA_BLO;
               end
            end
            I2CMA_ST1: state_q <= I2CMA_ST2;
            I2CMA_ST2: begin
               if (!ln.sda && !sda_drv_q) begin
                  sda_drv_q <= 1'b1;
               end
               if (brg_exp) begin
                  if (sda_drv_q) begin
                     scl_drv_q <= 1'b1;
                     state_q   <= I2CMA_IDLE;
                  end else begin
                     sda_drv_q <= 1'b1;
                  end
               end
            end
            I2CMA_RS1: if (brg_exp) begin
               scl_drv_q <= 1'b0;
               state_q   <= I2CMA_RS2;
            end
            I2CMA_RS2: if (ln.scl) state_q <= I2CMA_RS3;
            I2CMA_RS3: if (brg_exp) begin
               sda_drv_q <= 1'b1;
               state_q   <= I2CMA_RS4;
            end else if (!ln.sda) begin
               sda_drv_q <= 1'b1;
               state_q   <= I2CMA_RS4;
            end
            I2CMA_RS4: if (brg_exp) begin
               scl_drv_q <= 1'b1;
               state_q   <= I2CMA_IDLE;
            end
            I2CMA_BLO: if (brg_exp) begin
               scl_drv_q <= 1'b0;
               state_q   <= I2CMA_BHI;
            end else if (bit_q < 4'h8) begin
               sda_drv_q <= !shift_q[7];
            end else if (!seq_q[SEQ_ACK]) begin
               sda_drv_q <= 1'b0;
            end
            I2CMA_BHI: if (ln.scl && brg_exp) begin
               scl_drv_q <= 1'b1;
               if (bit_q == 4'h8) begin
                  if (!seq_q[SEQ_ACK]) nack_q <= ln.sda;
                  sda_drv_q <= 1'b0;
                  state_q   <= I2CMA_IDLE;
               end else begin
                  shift_q <= {shift_q[6:0], 1'b0};
                  bit_q   <= bit_q + 4'h1;
                  state_q <= I2CMA_BLO;
               end
            end
            I2CMA_SP1: if (!ln.sda && brg_exp) begin
               scl_drv_q <= 1'b0;
               state_q   <= I2CMA_SP2;
            end
            I2CMA_SP2: if (ln.scl && brg_exp) begin
               sda_drv_q <= 1'b0;
               state_q   <= I2CMA_SP3;
            end
            I2CMA_SP3: if (brg_exp) state_q <= I2CMA_IDLE;
            default: state_q <= I2CMA_IDLE;
         endcase
      end
   end

   // load from reload field on entry
   assign brg_load = (state_q == I2CMA_IDLE) || (brg_exp)
                  || (state_q == I2CMA_ST1) || (state_q == I2CMA_RS2)
                  || (state_q == I2CMA_ST2 && !ln.sda && !sda_drv_q)
                  || (state_q == I2CMA_SP1 && ln.sda)
                  || (state_q == I2CMA_SP2 && !ln.scl)
                  || (state_q == I2CMA_BHI && !ln.scl);
   assign brg_run  = (state_q != I2CMA_IDLE) && (state_q != I2CMA_ST1);

   assign seq_done = (state_q == I2CMA_ST2 && brg_exp && sda_drv_q)
                  || (state_q == I2CMA_RS4 && brg_exp)
                  || (state_q == I2CMA_SP3 && brg_exp)
                  || (state_q == I2CMA_BHI && ln.scl && brg_exp
                      && bit_q == 4'h8 && seq_q[SEQ_ACK]);
   assign byte_done = state_q == I2CMA_BHI && ln.scl && brg_exp
                   && bit_q == 4'h8 && !seq_q[SEQ_ACK];

   // Transfer buffer and write collision
   always_ff @(posedge clock) begin
      if (rst) begin
         buf_q  <= '0;
         full_q <= 1'b0;
         write_collision_flag_q <= 1'b0;
      end else begin
         if (wr && hit(req.adr, I2CMA_ADR_BUF)) begin
            if (state_q != I2CMA_IDLE || full_q) begin
               write_collision_flag_q <= 1'b1;
            end else begin
               buf_q  <= req.dat[7:0];
               full_q <= 1'b1;
            end
         end else if (wr && hit(req.adr, I2CMA_ADR_STATUS)
                      && req.dat[ST_WRITE_COLLISION_FLAG]) begin
            write_collision_flag_q <= 1'b0;
         end
         // full cleared on collision or once the byte is out
         if (bus_col || !en || byte_done) begin
            full_q <= 1'b0;
         end
      end
   end

   // Bus state flags and interrupt sources; on the interrupt sources set wins over a status-write clear
   // bus state flags cleared by reset or disable; interrupt sources by reset or a status write
   always_ff @(posedge clock) begin
      if (rst || !en) begin
         sflag_q <= 1'b0;
         pflag_q <= 1'b0;
      end else if (start_seen) begin
         sflag_q <= 1'b1;
         pflag_q <= 1'b0;
      end else if (stop_seen) begin
         sflag_q <= 1'b0;
         pflag_q <= 1'b1;
      end
   end

   always_ff @(posedge clock) begin
      if (rst) begin
         bcol_q <= 1'b0;
         pirq_q <= 1'b0;
      end else begin
         if (wr && hit(req.adr, I2CMA_ADR_STATUS) && req.dat[ST_BCOL]) begin
            bcol_q <= 1'b0;
         end
         if (wr && hit(req.adr, I2CMA_ADR_STATUS) && req.dat[ST_PIRQ]) begin
            pirq_q <= 1'b0;
         end
         if (bus_col) bcol_q <= 1'b1;
         // stop while enabled; also when a sequence step or a byte completes
         if ((en && stop_seen) || seq_done || byte_done) pirq_q <= 1'b1;
      end
   end

   assign irq  = ctrl_q[CTRL_IE] && (pirq_q || bcol_q);
   assign wake = ctrl_q[CTRL_SLEEP] && irq;

   // Open drain: enable low pulls the line low
   assign scl_o  = 1'b0;
   assign sda_o  = 1'b0;
   assign scl_oe = !scl_drv_q;
   assign sda_oe = !sda_drv_q;

   a_write_collision_flag_stop: assert property (@(posedge clock) disable iff (rst)
      (wr && hit(req.adr, I2CMA_ADR_BUF)
       && state_q inside {I2CMA_SP1, I2CMA_SP2, I2CMA_SP3})
      |=> write_collision_flag_q && buf_q == $past(buf_q))
      else $error("write during stop not flagged");
   a_col_release: assert property (@(posedge clock) disable iff (rst)
      bus_col && en |=> scl_oe && sda_oe && !full_q)
      else $error("lines not released after collision");
   a_col_flag: assert property (@(posedge clock) disable iff (rst)
      bus_col && en |=> bcol_q && state_q == I2CMA_IDLE)
      else $error("collision flag not set");
   a_col_seqclr: assert property (@(posedge clock) disable iff (rst)
      bus_col |=> seq_q[3:0] == 4'h0)
      else $error("sequence bits not cleared");
   a_flags_off: assert property (@(posedge clock) disable iff (rst)
      !en |=> !sflag_q && !pflag_q)
      else $error("bus flags survive disable");
   a_stop_irq: assert property (@(posedge clock) disable iff (rst)
      en && stop_seen |=> pirq_q)
      else $error("stop did not raise port flag");
   a_start_abort: assert property (@(posedge clock) disable iff (rst)
      en && state_q == I2CMA_ST1 && !ln.scl |=> state_q == I2CMA_IDLE)
      else $error("start not aborted");
   a_restart_col: assert property (@(posedge clock) disable iff (rst)
      en && state_q == I2CMA_RS3 && !ln.scl && ln.sda |=> bcol_q)
      else $error("restart scl fall not flagged");
endmodule
`default_nettype wire

/* File: inc/i2cma_pkg.sv */
// Constants, register map and carrier types for the i2c bus arbitration
// master. Assumes a classic Wishbone slave with 32-bit data.
package i2cma_pkg;
   localparam logic [7:0] I2CMA_ADR_CTRL   = 8'h00;
   localparam logic [7:0] I2CMA_ADR_SEQ    = 8'h04;
   localparam logic [7:0] I2CMA_ADR_STATUS = 8'h08;
   localparam logic [7:0] I2CMA_ADR_BAUD   = 8'h0C;
   localparam logic [7:0] I2CMA_ADR_BUF    = 8'h10;
   // Control bits
   localparam int CTRL_EN    = 0;
   localparam int CTRL_IE    = 1;
   localparam int CTRL_SLEEP = 2;
   // Sequence bits
   localparam int SEQ_START  = 0;
   localparam int SEQ_RSTART = 1;
   localparam int SEQ_STOP   = 2;
   localparam int SEQ_ACK    = 3;
   localparam int SEQ_ACKDT  = 4;
   // Status bits
   localparam int ST_FULL  = 0;
   localparam int ST_START = 1;
   localparam int ST_STOP  = 2;
   localparam int ST_WRITE_COLLISION_FLAG  = 3;
   localparam int ST_BCOL  = 4;
   localparam int ST_PIRQ  = 5;
   localparam int ST_NACK  = 6;
   localparam logic [6:0] I2CMA_BAUD_RESET = 7'h04;
   localparam int I2CMA_BAUD_W = 7;

   typedef enum logic [11:0] {
      I2CMA_IDLE  = 12'h001,
      I2CMA_ST1   = 12'h002,
      I2CMA_ST2   = 12'h004,
      I2CMA_RS1   = 12'h008,
      I2CMA_RS2   = 12'h010,
      I2CMA_RS3   = 12'h020,
      I2CMA_RS4   = 12'h040,
      I2CMA_BLO   = 12'h080,
      I2CMA_BHI   = 12'h100,
      I2CMA_SP1   = 12'h200,
      I2CMA_SP2   = 12'h400,
      I2CMA_SP3   = 12'h800
   } i2cma_state_type;

   typedef struct packed {
      logic scl;
      logic sda;
   } i2cma_lines_type;

   typedef struct packed {
      logic [7:0]  adr;
      logic        we;
      logic [3:0]  sel;
      logic [31:0] dat;
   } i2cma_req_type;
endpackage

/* File: core/i2cma_baud.sv */
// Baud generator: loads a 7-bit reload value and counts down to zero.
// Assumes the caller issues load and run as one-cycle level controls.
`timescale 1ns/1ps
`default_nettype none
module i2cma_baud #(
   parameter int WIDTH = 7
) (
   input  wire logic             clock,
   input  wire logic             rst,
   input  wire logic             load,
   input  wire logic             run,
   input  wire logic [WIDTH-1:0] reload,
   output logic                  expired
);
   logic [WIDTH-1:0] count_q;

   initial begin
      if (WIDTH < 2) $error("baud width too small");
   end

   always_ff @(posedge clock) begin
      if (rst) begin
         count_q <= '0;
      end else if (load) begin
         count_q <= reload;
      end else if (run && count_q != '0) begin
         count_q <= count_q - 1'b1;
      end
   end

   // Not gated by load: the caller reloads on expiry, gating would loop
   assign expired = run && (count_q == '0);
endmodule
`default_nettype wire

/* File: core/i2cma_sync.sv */
// Two-flop synchroniser for the bus lines, plus stop/start detection.
// Assumes the lines idle high when no one drives them.
`timescale 1ns/1ps
`default_nettype none
module i2cma_sync
   import i2cma_pkg::*;
(
   input  wire logic            clock,
   input  wire logic            rst,
   input  wire i2cma_pkg::i2cma_lines_type pins,
   output i2cma_pkg::i2cma_lines_type lines,
   output logic                 start_seen,
   output logic                 stop_seen
);
   i2cma_lines_type meta_q;
   i2cma_lines_type sync_q;
   i2cma_lines_type prev_q;

   always_ff @(posedge clock) begin
      if (rst) begin
         meta_q <= '1;
         sync_q <= '1;
         prev_q <= '1;
      end else begin
         meta_q <= pins;
         sync_q <= meta_q;
         prev_q <= sync_q;
      end
   end

   assign lines      = sync_q;
   assign start_seen = sync_q.scl && prev_q.scl && prev_q.sda && !sync_q.sda;
   assign stop_seen  = sync_q.scl && prev_q.scl && !prev_q.sda && sync_q.sda;
endmodule
`default_nettype wire

/* File: verif/i2cma_partner.sv */
// Far side of the two-wire bus: pull-ups, a rival master, a slow slave.
// Assumes the engine's oe outputs are low while it pulls a line low.
`timescale 1ns/1ps
`default_nettype none
module i2cma_partner (
   input  wire logic       clock,
   input  wire logic       rst,
   input  wire logic       scl_oe,
   input  wire logic       sda_oe,
   input  wire logic       sda_hold,
   input  wire logic       scl_hold,
   input  wire logic [3:0] stretch,
   output logic            scl,
   output logic            sda
);
   logic [3:0] hold_q;
   logic       scl_oe_q;
   logic       grab;
   // Stretch only on a release edge; a slave never starts a clock
   assign grab = scl_oe & ~scl_oe_q & (stretch != 4'h0);
   always_ff @(posedge clock) begin
      if (rst) begin
         hold_q   <= 4'h0;
         scl_oe_q <= 1'b1;
      end else begin
         scl_oe_q <= scl_oe;
         if (grab) begin
            hold_q <= stretch;
         end else if (hold_q != 4'h0) begin
            hold_q <= hold_q - 4'h1;
         end
      end
   end
   // Wired-and with pull-ups; the rival pulls low only when told
   assign scl = scl_oe & ~scl_hold & ~grab & (hold_q == 4'h0);
   assign sda = sda_oe & ~sda_hold;
endmodule
`default_nettype wire

/* File: verif/i2cma_tb_top.sv */
// Self-checking bench for the arbitration engine over Wishbone.
// Assumes the partner model stands on the bus lines.
`timescale 1ns/1ps
`default_nettype none
module i2cma_tb_top;
   import i2cma_pkg::*;
   logic            clock;
   logic            rst;
   logic            cyc;
   logic            stb;
   i2cma_req_type   req;
   logic [31:0]     dat_o;
   logic            ack;
   logic            scl;
   logic            sda;
   logic            scl_oe;
   logic            sda_oe;
   logic            irq;
   logic            wake;
   logic            sda_hold;
   logic            scl_hold;
   logic [3:0]      stretch;
   logic [31:0]     seed;
   logic [31:0]     q;
   int              mismatches;
   int              compares;
   int              baud;
   int              n;
   int              g;

   i2cma_top i2cma_top_inst (.clock(clock), .rst(rst), .wb_cyc_i(cyc),
      .wb_stb_i(stb), .wb_we_i(req.we), .wb_adr_i(req.adr),
      .wb_sel_i(req.sel), .wb_dat_i(req.dat), .wb_dat_o(dat_o),
      .wb_ack_o(ack), .scl_i(scl), .scl_o(), .scl_oe(scl_oe),
      .sda_i(sda), .sda_o(), .sda_oe(sda_oe), .irq(irq), .wake(wake));
   i2cma_partner i2cma_partner_inst (.clock(clock), .rst(rst),
      .scl_oe(scl_oe), .sda_oe(sda_oe), .sda_hold(sda_hold),
      .scl_hold(scl_hold), .stretch(stretch), .scl(scl), .sda(sda));

   always #2.5 clock = ~clock;

   function automatic logic [31:0] xs();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction

   task automatic summarize();
      $display("Counts: compares=%0d mismatches=%0d", compares, mismatches);
      if (mismatches == 0 && compares > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask

   task automatic chk(input string nm, input logic [31:0] e,
                      input logic [31:0] v);
      compares++;
      if (v !== e) begin
         mismatches++;
         $display("ERROR %s expected %0h seen %0h", nm, e, v);
      end
   endtask

   // Classic single cycle; held until ack is sampled high
   task automatic wb(input logic [7:0] a, input logic w,
                     input logic [31:0] d, output logic [31:0] r);
      int k;
      @(posedge clock);
      cyc <= 1'b1;
      stb <= 1'b1;
      req <= '{a, w, 4'hF, d};
      k = 0;
      do begin
         @(posedge clock);
         k++;
      end while (ack !== 1'b1 && k < 40);
      r = dat_o;
      cyc <= 1'b0;
      stb <= 1'b0;
      if (k >= 40) begin
         chk("ack wait", 32'h1, 32'h0);
         summarize();
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] r;
      wb(a, 1'b1, d, r);
   endtask

   // Polls one status bit under a bounded count
   task automatic poll(input int b, input logic v);
      int k;
      k = 0;
      do begin
         wb(I2CMA_ADR_STATUS, 1'b0, 32'h0, q);
         k++;
      end while (q[b] !== v && k < 400);
      if (k >= 400) begin
         chk($sformatf("status bit %0d", b), {31'h0, v}, {31'h0, q[b]});
         summarize();
      end
   endtask

   task automatic start_seq();
      wr(I2CMA_ADR_SEQ, 32'h1 << SEQ_START);
      n = 0;
      while (sda_oe !== 1'b0 && n < 300) begin
         @(posedge clock) #1;
         n++;
      end
      chk("scl at sda fall", 32'h1, {31'h0, scl_oe});
      g = 0;
      while (scl_oe !== 1'b0 && g < 300) begin
         @(posedge clock) #1;
         g++;
      end
      if (n >= 300 || g >= 300) begin
         chk("start wait", 32'h1, 32'h0);
         summarize();
      end
      chk("start low gap", 32'h1,
          {31'h0, g >= baud && g <= baud + 2});
   endtask

   initial begin
      clock = 1'b0;
      rst = 1'b1;
      cyc = 1'b0;
      stb = 1'b0;
      req = '0;
      sda_hold = 1'b0;
      scl_hold = 1'b0;
      stretch = 4'h0;
      seed = 32'h2C94;
      mismatches = 0;
      compares = 0;
      repeat (5) @(posedge clock);
      rst <= 1'b0;
      wb(I2CMA_ADR_STATUS, 1'b0, 32'h0, q);
      chk("status reset", 32'h0, q & 32'h7F);
      wb(I2CMA_ADR_BAUD, 1'b0, 32'h0, q);
      chk("baud reset", {25'h0, I2CMA_BAUD_RESET}, q & 32'h7F);
      chk("lines released", 32'h3, {30'h0, scl_oe, sda_oe});
      baud = 4 + (xs() % 6);
      wr(I2CMA_ADR_BAUD, baud);
      wr(I2CMA_ADR_CTRL, 32'h3);
      for (int k = 0; k < 2; k++) begin
         sda_hold <= (k == 0);
         scl_hold <= (k == 1);
         repeat (4) @(posedge clock);
         wr(I2CMA_ADR_SEQ, 32'h1 << SEQ_START);
         poll(ST_BCOL, 1'b1);
         wb(I2CMA_ADR_SEQ, 1'b0, 32'h0, q);
         chk("seq cleared", 32'h0, q & 32'h7);
         chk("abort released", 32'h3, {30'h0, scl_oe, sda_oe});
         chk("irq on bcol", 32'h1, {31'h0, irq});
         sda_hold <= 1'b0;
         scl_hold <= 1'b0;
         wr(I2CMA_ADR_STATUS, 32'h38);
         wb(I2CMA_ADR_STATUS, 1'b0, 32'h0, q);
         chk("bcol cleared", 32'h0, q & 32'h10);
      end
      start_seq();
      wb(I2CMA_ADR_STATUS, 1'b0, 32'h0, q);
      chk("start seen", 32'h2, q & 32'h6);
      // Finished START left the port flag up; clear it before the STOP
      wr(I2CMA_ADR_STATUS, 32'h20);
      wr(I2CMA_ADR_SEQ, 32'h1 << SEQ_STOP);
      wr(I2CMA_ADR_BUF, 32'hA5);
      poll(ST_PIRQ, 1'b1);
      wb(I2CMA_ADR_STATUS, 1'b0, 32'h0, q);
      chk("after stop", 32'h2C, q & 32'h3F);
      chk("stop released", 32'h3, {30'h0, scl_oe, sda_oe});
      chk("irq after stop", 32'h1, {31'h0, irq});
      wr(I2CMA_ADR_STATUS, 32'h38);
      start_seq();
      wr(I2CMA_ADR_BUF, {24'h0, 8'(xs()) | 8'h80});
      stretch <= 4'(xs() % 4);
      wb(I2CMA_ADR_STATUS, 1'b0, 32'h0, q);
      chk("full on write", 32'h1, q & 32'h1);
      sda_hold <= 1'b1;
      poll(ST_BCOL, 1'b1);
      wb(I2CMA_ADR_STATUS, 1'b0, 32'h0, q);
      chk("full dropped", 32'h0, q & 32'h1);
      chk("tx released", 32'h3, {30'h0, scl_oe, sda_oe});
      wr(I2CMA_ADR_STATUS, 32'h38);
      wr(I2CMA_ADR_CTRL, 32'h7);
      stretch <= 4'h0;
      sda_hold <= 1'b0;
      poll(ST_PIRQ, 1'b1);
      chk("wake on irq", 32'h1, {31'h0, wake});
      wr(I2CMA_ADR_CTRL, 32'h3);
      wr(I2CMA_ADR_STATUS, 32'h38);
      wr(I2CMA_ADR_BUF, {24'h0, 8'(xs()) & 8'h7F});
      wb(I2CMA_ADR_STATUS, 1'b0, 32'h0, q);
      chk("write after bcol", 32'h1, q & 32'h1);
      poll(ST_FULL, 1'b0);
      // Restart: rival pulls SCL early in the second count, then clean
      wr(I2CMA_ADR_STATUS, 32'h38);
      wr(I2CMA_ADR_SEQ, 32'h1 << SEQ_RSTART);
      n = 0;
      while (scl_oe !== 1'b1 && n < 300) begin
         @(posedge clock) #1;
         n++;
      end
      repeat (3) @(posedge clock);
      scl_hold <= 1'b1;
      poll(ST_BCOL, 1'b1);
      chk("restart abort", 32'h3, {30'h0, scl_oe, sda_oe});
      scl_hold <= 1'b0;
      wr(I2CMA_ADR_STATUS, 32'h38);
      wr(I2CMA_ADR_SEQ, 32'h1 << SEQ_RSTART);
      poll(ST_PIRQ, 1'b1);
      chk("restart drives", 32'h0, {30'h0, scl_oe, sda_oe});
      wr(I2CMA_ADR_CTRL, 32'h0);
      wb(I2CMA_ADR_STATUS, 1'b0, 32'h0, q);
      chk("flags on disable", 32'h0, q & 32'h6);
      wr(I2CMA_ADR_CTRL, 32'h1);
      wr(I2CMA_ADR_SEQ, 32'h1 << SEQ_START);
      repeat (3) @(posedge clock);
      rst <= 1'b1;
      repeat (2) @(posedge clock);
      rst <= 1'b0;
      @(posedge clock) #1;
      chk("reset released", 32'h3, {30'h0, scl_oe, sda_oe});
      wb(I2CMA_ADR_CTRL, 1'b0, 32'h0, q);
      chk("reset disables", 32'h0, q & 32'h7);
      wb(I2CMA_ADR_STATUS, 1'b0, 32'h0, q);
      chk("reset flags", 32'h0, q & 32'h3F);
      summarize();
   end
endmodule
`default_nettype wire
